// ### logic/swsc_sensor.sv
// Command and transaction layer of a single-wire temperature sensor.
// Assumes one bus master; the conversion itself is done outside.
//
// Overview of operation
// - A low line longer than 480 us resets the bus and drops any transfer.
// - Any idle gap between bits is fine while the line stays high.
// - Answer only after init, ROM command, function command, in order.
// - Each transfer opens with master reset; device answers with presence.
// - Five ROM commands of 8 bits follow presence, before functions.
// - Read identity command sends the whole 64-bit identity code.
// - Match command selects only on an exact 64-bit match.
// - Skip command selects the device without any identity code.
// - Alarm search works as search but only with alarm flag set.
// - Convert command runs one conversion into the temperature bytes.
// - Read slots after convert give 0 busy, 1 done, external supply.
// - Scratchpad write takes three bytes lsb first into bytes 2 to 4.
// - Scratchpad read sends byte 0 lsb first through check byte 8.
// - Master may cut a scratchpad read by reset; device drops it.
// - Copy command stores bytes 2 to 4 into nonvolatile storage.
// - Recall reloads bytes 2 to 4; read slots show 0 busy, 1 done, external supply.
// - Reload from nonvolatile storage happens by itself after power-up.
// - Every command and data byte travels lsb first.
// - Presence waits 15 to 60 us, then drives low 60 to 240 us.
// - Write slots are sampled 15 to 60 us after the falling edge.
// - Read slot bit is held 45 us and released before slot end.
`timescale 1ns/1ps
module swsc_sensor
	import swsc_pkg::*;
#(
	// Arbitrary identity values, not those of any real part
	parameter logic [7:0]  FAMILY_CODE = 8'h5a,
	parameter logic [47:0] SERIAL_NUM  = 48'h0000_0000_0001,
	parameter int          NV_CYCLES   = 1000,
	parameter int          US_DIV      = US_CYCLES
)(
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        dq_in,
	output logic             dq_out,
	output logic             dq_oe,
	input  wire logic        parasite_mode,
	input  wire logic [15:0] temp_in,
	input  wire logic        conv_done,
	output logic             conv_start,
	output logic             alarm_flag
);

	localparam logic [63:0] ROM_CODE = {
		swsc_crc8({8'h00, SERIAL_NUM, FAMILY_CODE}, 56),
		SERIAL_NUM, FAMILY_CODE};

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		swsc_top_st_t st;
		logic [6:0]   cnt;
		logic [1:0]   ph;
		logic [7:0]   rxb;
		logic [7:0]   th;
		logic [7:0]   tl;
		logic [7:0]   cfg;
		logic [15:0]  temp;
		logic         alarm;
		logic         conv_busy;
		logic         conv_start;
		logic         copy_req;
		logic         recall_req;
		logic         boot;
	} swsc_top_s_t;

	swsc_top_s_t s_r;
	swsc_top_s_t s_nxt;
	logic [63:0] sp_low;
	logic [71:0] sp_vec;
	logic [7:0]  nb;
	logic        rom_bit;
	logic        op_busy;
	logic        last_cmd;
	logic        hot;
	logic        cold;

	swsc_link_if lnk ();
	swsc_nv_if   nv ();

	swsc_slot #(
		.US_DIV (US_DIV)
	) u_slot (
		.clock  (clock),
		.resetn (resetn),
		.dq_in  (dq_in),
		.dq_out (dq_out),
		.dq_oe  (dq_oe),
		.lnk    (lnk.slot)
	);

	swsc_nv #(
		.NV_CYCLES (NV_CYCLES)
	) u_nv (
		.clock  (clock),
		.resetn (resetn),
		.nv     (nv.mem)
	);

	assign sp_low = {RSV7_VAL, RSV6_VAL, RSV5_VAL, s_r.cfg, s_r.tl, s_r.th,
	                 s_r.temp};
	assign sp_vec = {swsc_crc8(sp_low, 64), sp_low};
	// Bytes arrive lsb first, so each new bit enters at the top
	assign nb = {lnk.bit_val, s_r.rxb[7:1]};
	assign rom_bit = ROM_CODE[s_r.cnt[5:0]];
	assign op_busy = s_r.conv_busy | nv.busy | s_r.recall_req;
	assign last_cmd = (s_r.cnt == LAST_CMD_BIT);
	assign hot = $signed(temp_in[11:4]) >= $signed(s_r.th);
	assign cold = $signed(temp_in[11:4]) <= $signed(s_r.tl);

	// ----------------------------------------------------------------
	// What the device offers in the next read slot
	// ----------------------------------------------------------------
	always_comb begin
		lnk.tx_en = 1'b0;
		lnk.tx_bit = 1'b1;
		case (s_r.st)
		T_READ_ROM: begin
			lnk.tx_en = 1'b1;
			lnk.tx_bit = rom_bit;
		end
		T_SEARCH: begin
			lnk.tx_en = (s_r.ph != 2'h2);
			lnk.tx_bit = (s_r.ph == 2'h0) ? rom_bit : ~rom_bit;
		end
		T_READ_SP: begin
			lnk.tx_en = 1'b1;
			lnk.tx_bit = sp_vec[s_r.cnt];
		end
		T_STATUS: begin
			// Line is held high by the strong pullup in parasite mode
			lnk.tx_en = ~parasite_mode;
			lnk.tx_bit = ~op_busy;
		end
		default: begin
			lnk.tx_en = 1'b0;
			lnk.tx_bit = 1'b1;
		end
		endcase
	end

	// ----------------------------------------------------------------
	// Transaction sequencing
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.conv_start = 1'b0;
		s_nxt.copy_req = 1'b0;
		s_nxt.recall_req = 1'b0;
		if (s_r.boot) begin
			s_nxt.boot = 1'b0;
			s_nxt.recall_req = 1'b1;
		end
		if (nv.recall_done) begin
			{s_nxt.cfg, s_nxt.tl, s_nxt.th} = nv.rd_data;
		end
		if (conv_done) begin
			s_nxt.temp = temp_in;
			s_nxt.conv_busy = 1'b0;
			s_nxt.alarm = hot | cold;
		end
		if (lnk.bus_reset) begin
			s_nxt.st = T_ROM_CMD;
			s_nxt.cnt = 7'h00;
			s_nxt.ph = 2'h0;
		end else if (lnk.bit_evt) begin
			case (s_r.st)
			T_ROM_CMD: begin
				s_nxt.rxb = nb;
				s_nxt.cnt = s_r.cnt + 7'h01;
				if (last_cmd) begin
					s_nxt.cnt = 7'h00;
					// Unknown codes leave the device silent
					if (nb == ROM_READ)
						s_nxt.st = T_READ_ROM;
					else if (nb == ROM_MATCH)
						s_nxt.st = T_MATCH;
					else if (nb == ROM_SKIP)
						s_nxt.st = T_FUNC_CMD;
					else if (nb == ROM_SEARCH)
						s_nxt.st = T_SEARCH;
					else if (nb == ROM_ALARM)
						s_nxt.st = s_r.alarm ? T_SEARCH : T_DONE;
					else
						s_nxt.st = T_DONE;
				end
			end
			T_READ_ROM: begin
				s_nxt.cnt = s_r.cnt + 7'h01;
				if (s_r.cnt == LAST_ROM_BIT) begin
					s_nxt.cnt = 7'h00;
					s_nxt.st = T_FUNC_CMD;
				end
			end
			T_MATCH: begin
				s_nxt.cnt = s_r.cnt + 7'h01;
				if (lnk.bit_val != rom_bit) begin
					s_nxt.st = T_DONE;
				end else if (s_r.cnt == LAST_ROM_BIT) begin
					s_nxt.cnt = 7'h00;
					s_nxt.st = T_FUNC_CMD;
				end
			end
			T_SEARCH: begin
				if (s_r.ph != 2'h2) begin
					s_nxt.ph = s_r.ph + 2'h1;
				end else begin
					s_nxt.ph = 2'h0;
					s_nxt.cnt = s_r.cnt + 7'h01;
					// Function commands are not taken after a search
					if (lnk.bit_val != rom_bit || s_r.cnt == LAST_ROM_BIT)
						s_nxt.st = T_DONE;
				end
			end
			T_FUNC_CMD: begin
				s_nxt.rxb = nb;
				s_nxt.cnt = s_r.cnt + 7'h01;
				if (last_cmd) begin
					s_nxt.cnt = 7'h00;
					if (nb == FN_CONVERT) begin
						s_nxt.conv_start = 1'b1;
						s_nxt.conv_busy = 1'b1;
						s_nxt.st = T_STATUS;
					end else if (nb == FN_WRITE) begin
						s_nxt.st = T_WRITE_SP;
					end else if (nb == FN_READ) begin
						s_nxt.st = T_READ_SP;
					end else if (nb == FN_COPY && !nv.busy) begin
						s_nxt.copy_req = 1'b1;
						s_nxt.st = T_DONE;
					end else if (nb == FN_RECALL && !nv.busy) begin
						s_nxt.recall_req = 1'b1;
						s_nxt.st = T_STATUS;
					end else begin
						s_nxt.st = T_DONE;
					end
				end
			end
			T_WRITE_SP: begin
				s_nxt.rxb = nb;
				s_nxt.cnt = s_r.cnt + 7'h01;
				// Each byte lands when whole; a cut write keeps earlier ones
				if (s_r.cnt[2:0] == 3'h7) begin
					if (s_r.cnt[4:3] == 2'h0) begin
						s_nxt.th = nb;
					end else if (s_r.cnt[4:3] == 2'h1) begin
						s_nxt.tl = nb;
					end else begin
						s_nxt.cfg = (nb & CFG_RW_MASK) | CFG_FIXED;
						s_nxt.st = T_DONE;
					end
				end
			end
			T_READ_SP: begin
				s_nxt.cnt = s_r.cnt + 7'h01;
				if (s_r.cnt == LAST_SP_BIT)
					s_nxt.st = T_DONE;
			end
			default: s_nxt.st = s_r.st;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			s_r <= '{st: T_IDLE, cnt: 7'h00, ph: 2'h0, rxb: 8'h00,
			         th: NV_RST[7:0], tl: NV_RST[15:8],
			         cfg: NV_RST[23:16], temp: TEMP_RST, alarm: 1'b0,
			         conv_busy: 1'b0, conv_start: 1'b0, copy_req: 1'b0,
			         recall_req: 1'b0, boot: 1'b1};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign nv.copy_req = s_r.copy_req;
	assign nv.recall_req = s_r.recall_req;
	assign nv.wr_data = {s_r.cfg, s_r.tl, s_r.th};
	assign conv_start = s_r.conv_start;
	assign alarm_flag = s_r.alarm;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	a_reset_abandon: assert property (lnk.bus_reset |=>
		s_r.st == T_ROM_CMD && s_r.cnt == 7'h00)
		else $error("bus reset did not restart the sequence");
	a_silent_unsel: assert property (s_r.st inside {T_IDLE, T_DONE,
		T_MATCH, T_FUNC_CMD, T_ROM_CMD} |-> !lnk.tx_en)
		else $error("device drove while not selected");
	a_match_miss: assert property (s_r.st == T_MATCH && lnk.bit_evt &&
		!lnk.bus_reset && lnk.bit_val != rom_bit |=> s_r.st == T_DONE)
		else $error("mismatching code did not deselect");
	a_skip_select: assert property (s_r.st == T_ROM_CMD &&
		lnk.bit_evt && !lnk.bus_reset && last_cmd && nb == ROM_SKIP
		|=> s_r.st == T_FUNC_CMD) else $error("skip did not select");
	a_alarm_gate: assert property (s_r.st == T_ROM_CMD &&
		lnk.bit_evt && !lnk.bus_reset && last_cmd && nb == ROM_ALARM &&
		!s_r.alarm |=> s_r.st == T_DONE)
		else $error("alarm search joined without alarm");
	a_conv_launch: assert property (s_r.st == T_FUNC_CMD &&
		lnk.bit_evt && !lnk.bus_reset && last_cmd && nb == FN_CONVERT
		|=> conv_start && s_r.st == T_STATUS ##1 !conv_start)
		else $error("convert not started once");
	a_conv_status: assert property (s_r.st == T_STATUS &&
		s_r.conv_busy && !parasite_mode |-> lnk.tx_en && !lnk.tx_bit)
		else $error("busy conversion reported done");
	a_cfg_fixed: assert property ((s_r.cfg & ~CFG_RW_MASK) == CFG_FIXED)
		else $error("reserved config bits changed");
	a_boot_reload: assert property ($fell(s_r.boot) |->
		s_r.recall_req ##1 nv.busy) else $error("no reload after reset");
	a_search_step: assert property (s_r.st == T_SEARCH &&
		s_r.ph == 2'h1 |-> lnk.tx_en && lnk.tx_bit == !rom_bit)
		else $error("search complement wrong");

	c_read_rom: cover property (s_r.st == T_READ_ROM ##1
		s_r.st == T_FUNC_CMD);
	c_search_end: cover property (s_r.st == T_SEARCH &&
		s_r.cnt == LAST_ROM_BIT ##1 s_r.st == T_DONE);
	c_write_sp: cover property (s_r.st == T_WRITE_SP ##1 s_r.st == T_DONE);
	c_read_sp: cover property (s_r.st == T_READ_SP &&
		s_r.cnt == LAST_SP_BIT ##1 s_r.st == T_DONE);

endmodule

// ### logic/swsc_pkg.sv
// Shared constants, commands and helpers of the sensor command layer.
// Assumes one 100 MHz clock; line timing is counted in 1 us ticks.
package swsc_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_TICK_NS     = 1000;
	localparam int US_CYCLES     = T_TICK_NS / CLK_PERIOD_NS;
	localparam logic [6:0] DIV_LAST = 7'(US_CYCLES - 1);
	localparam int T_RESET_US    = 480;
	localparam int T_PD_WAIT_US  = 30;
	localparam int T_PD_LOW_US   = 120;
	localparam int T_SAMPLE_US   = 30;
	localparam int T_TX_HOLD_US  = 45;
	localparam int T_SLOT_US     = 60;
	localparam logic [8:0] RESET_TICKS   = 9'(T_RESET_US);
	localparam logic [8:0] PD_WAIT_TICKS = 9'(T_PD_WAIT_US);
	localparam logic [8:0] PD_LOW_TICKS  = 9'(T_PD_LOW_US);
	localparam logic [8:0] SAMPLE_TICKS  = 9'(T_SAMPLE_US);
	localparam logic [8:0] HOLD_TICKS    = 9'(T_TX_HOLD_US);
	localparam logic [8:0] SLOT_TICKS    = 9'(T_SLOT_US);
	localparam logic [8:0] US_MAX        = 9'h1ff;

	// ----------------------------------------------------------------
	// Commands and bit counts
	// ----------------------------------------------------------------
	localparam logic [7:0] ROM_READ   = 8'h33;
	localparam logic [7:0] ROM_MATCH  = 8'h55;
	localparam logic [7:0] ROM_SKIP   = 8'hcc;
	localparam logic [7:0] ROM_SEARCH = 8'hf0;
	localparam logic [7:0] ROM_ALARM  = 8'hec;
	localparam logic [7:0] FN_CONVERT = 8'h44;
	localparam logic [7:0] FN_WRITE   = 8'h4e;
	localparam logic [7:0] FN_READ    = 8'hbe;
	localparam logic [7:0] FN_COPY    = 8'h48;
	localparam logic [7:0] FN_RECALL  = 8'hb8;
	localparam logic [6:0] LAST_CMD_BIT = 7'h07;
	localparam logic [6:0] LAST_ROM_BIT = 7'h3f;
	localparam logic [6:0] LAST_SP_BIT  = 7'h47;

	// ----------------------------------------------------------------
	// Scratchpad and storage values after reset
	// ----------------------------------------------------------------
	localparam logic [15:0] TEMP_RST    = 16'h0550;
	localparam logic [7:0]  RSV5_VAL    = 8'hff;
	localparam logic [7:0]  RSV6_VAL    = 8'h00;
	localparam logic [7:0]  RSV7_VAL    = 8'h10;
	localparam logic [7:0]  CFG_RW_MASK = 8'h60;
	localparam logic [7:0]  CFG_FIXED   = 8'h1f;
	localparam logic [23:0] NV_RST      = 24'h7f_80_7f;

	typedef enum logic [3:0] {
		T_IDLE, T_ROM_CMD, T_READ_ROM, T_MATCH, T_SEARCH,
		T_FUNC_CMD, T_WRITE_SP, T_READ_SP, T_STATUS, T_DONE
	} swsc_top_st_t;

	typedef enum logic [2:0] {
		S_IDLE, S_SLOT, S_RST, S_PD_WAIT, S_PD_LOW
	} swsc_slot_st_t;

	// Check byte, x8+x5+x4+1, shifted in lsb first over the first n bits
	function automatic logic [7:0] swsc_crc8(input logic [63:0] d,
	                                         input int n);
		logic [7:0] c;
		logic       fb;
		c = 8'h00;
		for (int i = 0; i < 64; i++) begin
			if (i < n) begin
				fb = c[0] ^ d[i];
				c  = {1'b0, c[7:1]} ^ (fb ? 8'h8c : 8'h00);
			end
		end
		return c;
	endfunction

endpackage

// ### logic/swsc_link_if.sv
// Carriers between the command layer, its slot engine and its storage.
// Assumes all parties run on the same clock.
`timescale 1ns/1ps
interface swsc_link_if;
	logic bus_reset;
	logic bit_evt;
	logic bit_val;
	logic tx_en;
	logic tx_bit;
	modport slot (output bus_reset, bit_evt, bit_val, input tx_en, tx_bit);
	modport cmd  (input bus_reset, bit_evt, bit_val, output tx_en, tx_bit);
endinterface

interface swsc_nv_if;
	logic        copy_req;
	logic        recall_req;
	logic [23:0] wr_data;
	logic [23:0] rd_data;
	logic        busy;
	logic        recall_done;
	modport mem (input copy_req, recall_req, wr_data,
	             output rd_data, busy, recall_done);
	modport cmd (output copy_req, recall_req, wr_data,
	             input rd_data, busy, recall_done);
endinterface

// ### logic/swsc_slot.sv
// Line timing: reset and presence, bit slot sampling and driving.
// Assumes an open-drain data line with external pullup; dq_in is async.
`timescale 1ns/1ps
module swsc_slot
	import swsc_pkg::*;
#(
	parameter int US_DIV = US_CYCLES
)(
	input  wire logic   clock,
	input  wire logic   resetn,
	input  wire logic   dq_in,
	output logic        dq_out,
	output logic        dq_oe,
	swsc_link_if.slot   lnk
);

	// The fall is seen three cycles late; a 1 us master pulse must cover it
	if (US_DIV < 4 || US_DIV > 128) begin : g_chk
		$error("US_DIV out of range");
	end

	localparam logic [6:0] DIV_END = 7'(US_DIV - 1);

	typedef struct packed {
		logic [2:0]    sync;
		swsc_slot_st_t st;
		logic [6:0]    div;
		logic [8:0]    us;
		logic          drive;
		logic          bit_evt;
		logic          bit_val;
		logic          bus_reset;
	} swsc_slot_s_t;

	swsc_slot_s_t s_r;
	swsc_slot_s_t s_nxt;
	logic         line;
	logic         fell;
	logic         tick;
	logic [8:0]   us_inc;

	assign line = s_r.sync[1];
	assign fell = s_r.sync[2] & ~line;
	assign tick = (s_r.div == DIV_END);
	assign us_inc = (tick && s_r.us != US_MAX) ? s_r.us + 9'h001 : s_r.us;

	// ----------------------------------------------------------------
	// Slot sequencing
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.bit_evt = 1'b0;
		s_nxt.bus_reset = 1'b0;
		s_nxt.sync = {s_r.sync[1:0], dq_in};
		s_nxt.div = tick ? 7'h00 : s_r.div + 7'h01;
		s_nxt.us = us_inc;
		case (s_r.st)
		S_IDLE: begin
			// No timeout here: a released line may rest for ever
			if (fell) begin
				s_nxt.st = S_SLOT;
				s_nxt.us = 9'h000;
				s_nxt.div = 7'h00;
				// Bit latched at the fall so it cannot change mid-slot
				s_nxt.drive = lnk.tx_en & ~lnk.tx_bit;
			end
		end
		S_SLOT: begin
			if (tick && us_inc == SAMPLE_TICKS) begin
				s_nxt.bit_evt = 1'b1;
				s_nxt.bit_val = line;
			end
			if (us_inc >= HOLD_TICKS)
				s_nxt.drive = 1'b0;
			if (!line && s_r.us >= RESET_TICKS) begin
				s_nxt.bus_reset = 1'b1;
				s_nxt.st = S_RST;
				s_nxt.drive = 1'b0;
			end else if (line && s_r.us >= SLOT_TICKS) begin
				s_nxt.st = S_IDLE;
			end
		end
		S_RST: begin
			if (line) begin
				s_nxt.st = S_PD_WAIT;
				s_nxt.us = 9'h000;
				s_nxt.div = 7'h00;
			end
		end
		S_PD_WAIT: begin
			if (us_inc >= PD_WAIT_TICKS) begin
				s_nxt.st = S_PD_LOW;
				s_nxt.us = 9'h000;
				s_nxt.drive = 1'b1;
			end
		end
		S_PD_LOW: begin
			if (us_inc >= PD_LOW_TICKS) begin
				s_nxt.st = S_IDLE;
				s_nxt.drive = 1'b0;
			end
		end
		default: s_nxt.st = S_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			s_r <= '{sync: 3'h7, st: S_IDLE, div: 7'h00, us: 9'h000,
			         drive: 1'b0, bit_evt: 1'b0, bit_val: 1'b0,
			         bus_reset: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign dq_out = 1'b0;
	assign dq_oe = s_r.drive;
	assign lnk.bit_evt = s_r.bit_evt;
	assign lnk.bit_val = s_r.bit_val;
	assign lnk.bus_reset = s_r.bus_reset;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	a_sample_point: assert property (s_r.bit_evt |-> s_r.st == S_SLOT &&
		s_r.us == SAMPLE_TICKS) else $error("write slot sampled off time");
	a_reset_length: assert property (s_r.bus_reset |->
		s_r.us >= RESET_TICKS && s_r.st == S_RST)
		else $error("bus reset before full low time");
	a_tx_release: assert property (s_r.st == S_SLOT &&
		s_r.us >= HOLD_TICKS |-> !dq_oe) else $error("line held too long");
	a_pres_window: assert property ($rose(s_r.st == S_PD_LOW) |->
		dq_oe && s_r.us == 9'h000 &&
		$past(s_r.us) == PD_WAIT_TICKS - 9'h001)
		else $error("presence pulse started off time");
	c_presence: cover property (s_r.st == S_PD_LOW ##1 s_r.st == S_IDLE);

endmodule

// ### logic/swsc_nv.sv
// Nonvolatile copy of the alarm and configuration bytes.
// Assumes a request is only made while busy is low.
`timescale 1ns/1ps
module swsc_nv
	import swsc_pkg::*;
#(
	parameter int NV_CYCLES = 1000
)(
	input  wire logic clock,
	input  wire logic resetn,
	swsc_nv_if.mem    nv
);

	if (NV_CYCLES < 1 || NV_CYCLES > 65535) begin : g_chk
		$error("NV_CYCLES out of range");
	end

	localparam logic [15:0] NV_LAST = 16'(NV_CYCLES - 1);

	typedef struct packed {
		logic [23:0] store;
		logic [23:0] pend;
		logic        busy;
		logic        is_copy;
		logic [15:0] cnt;
		logic        done;
	} swsc_nv_s_t;

	swsc_nv_s_t s_r;
	swsc_nv_s_t s_nxt;

	// Storage is modelled by flops whose reset value stands for the
	// contents kept across power-down.
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		if (s_r.busy) begin
			if (s_r.cnt == NV_LAST) begin
				s_nxt.busy = 1'b0;
				if (s_r.is_copy)
					s_nxt.store = s_r.pend;
				else
					s_nxt.done = 1'b1;
			end else begin
				s_nxt.cnt = s_r.cnt + 16'h0001;
			end
		end else if (nv.copy_req || nv.recall_req) begin
			s_nxt.busy = 1'b1;
			s_nxt.is_copy = nv.copy_req;
			s_nxt.pend = nv.wr_data;
			s_nxt.cnt = 16'h0000;
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			s_r <= '{store: NV_RST, pend: 24'h000000, busy: 1'b0,
			         is_copy: 1'b0, cnt: 16'h0000, done: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign nv.rd_data = s_r.store;
	assign nv.busy = s_r.busy;
	assign nv.recall_done = s_r.done;

endmodule

// ### testbench/swsc_master.sv
// Bus master model that drives the open-drain data line.
// Assumes a 100 MHz clock; the line is pulled up when nobody pulls low.
`timescale 1ns/1ps
module swsc_master #(
	parameter int US = 100
)(
	input  wire logic clock,
	input  wire logic dev_oe,
	output logic      line
);
	logic m_oe;

	// Released line reads high through the pullup
	assign line = !(m_oe || dev_oe);
	initial m_oe = 1'b0;

	task automatic hold(input int n);
		repeat (n) @(posedge clock);
	endtask

	// Low for 485 us, then time the answer; loops are bounded
	task automatic bus_reset(output int wt, output int lo);
		wt = 0;
		lo = 0;
		@(posedge clock) m_oe <= 1'b1;
		hold(485 * US);
		m_oe <= 1'b0;
		// Let the release reach the line before timing the wait
		@(negedge clock);
		while (line && wt < 90 * US) begin
			@(negedge clock);
			wt++;
		end
		while (!line && lo < 300 * US) begin
			@(negedge clock);
			lo++;
		end
		hold(10 * US);
	endtask

	// Slots of 65 us, release early for a one
	task automatic write_bit(input logic b);
		@(posedge clock) m_oe <= 1'b1;
		hold(b ? 5 * US : 62 * US);
		m_oe <= 1'b0;
		hold(b ? 60 * US : 3 * US);
	endtask

	// Bytes go lsb first
	task automatic write_byte(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			write_bit(b[i]);
		end
	endtask

	// Sample at 12 us, inside the device's 45 us valid time
	task automatic read_bit(output logic v);
		@(posedge clock) m_oe <= 1'b1;
		hold(US);
		m_oe <= 1'b0;
		hold(11 * US);
		@(negedge clock) v = line;
		hold(53 * US);
	endtask
endmodule

// ### testbench/tb_top.sv
// Self-checking bench for the sensor command layer.
// Assumes the master model above; a faster tick scales all line timing.
`timescale 1ns/1ps
module tb_top;
	import swsc_pkg::*;
	logic        clock;
	logic        resetn;
	logic        dq_out;
	logic        dq_oe;
	logic        parasite_mode;
	logic        conv_done;
	logic        conv_start;
	logic        alarm_flag;
	logic        line;
	logic [15:0] temp_in;
	int          fail_count;
	int          checks_done;
	int          starts;

	// A fast microsecond tick keeps the run short
	localparam int         TB_US  = 4;
	// Family code fixed here so search answers are known; value arbitrary
	localparam logic [7:0] ID_LOW = 8'h5a;

	swsc_sensor #(
		.FAMILY_CODE (ID_LOW),
		.NV_CYCLES   (4),
		.US_DIV      (TB_US)
	) DUT (
		.clock(clock), .resetn(resetn), .dq_in(line), .dq_out(dq_out),
		.dq_oe(dq_oe), .parasite_mode(parasite_mode), .temp_in(temp_in),
		.conv_done(conv_done), .conv_start(conv_start),
		.alarm_flag(alarm_flag)
	);
	swsc_master #(.US(TB_US)) u_m (
		.clock(clock), .dev_oe(dq_oe), .line(line)
	);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	always @(posedge clock) begin
		if (conv_start === 1'b1)
			starts <= starts + 1;
	end

	task automatic check(input string nm, input logic [15:0] e,
	                     input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic t_presence;
		int wt;
		int lo;
		u_m.bus_reset(wt, lo);
		check("pd_wait", 1, 16'(wt >= 15*TB_US && wt <= 61*TB_US));
		check("pd_low", 1, 16'(lo >= 60*TB_US && lo <= 240*TB_US));
		check("dq_out", 0, {15'h0, dq_out});
	endtask

	task automatic t_convert;
		logic v;
		t_presence();
		u_m.write_byte(ROM_SKIP);
		u_m.write_byte(FN_CONVERT);
		check("conv_start", 1, 16'(starts));
		u_m.read_bit(v);
		check("busy_bit", 0, {15'h0, v});
		@(posedge clock);
		conv_done <= 1'b1;
		temp_in   <= 16'h0191;
		@(posedge clock) conv_done <= 1'b0;
		u_m.read_bit(v);
		check("done_bit", 1, {15'h0, v});
		check("alarm", 0, {15'h0, alarm_flag});
		$display("test convert done");
	endtask

	// Function code sent in place of a ROM command must stay unanswered
	task automatic t_order;
		logic v;
		t_presence();
		u_m.write_byte(FN_CONVERT);
		u_m.read_bit(v);
		check("no_start", 1, 16'(starts));
		check("silent", 1, {15'h0, v});
		$display("test order done");
	endtask

	task automatic t_read_abort;
		logic [7:0] b;
		logic       v;
		t_presence();
		u_m.write_byte(ROM_SKIP);
		u_m.write_byte(FN_READ);
		for (int i = 0; i < 8; i++) begin
			u_m.read_bit(b[i]);
		end
		check("sp_byte0", 16'h0091, {8'h00, b});
		t_presence();
		u_m.read_bit(v);
		check("dropped", 1, {15'h0, v});
		$display("test read abort done");
	endtask

	// Three bytes written, then read back after a fresh selection
	task automatic t_write;
		logic [39:0] r;
		logic [7:0]  cfg_exp;
		cfg_exp = (8'h20 & CFG_RW_MASK) | CFG_FIXED;
		t_presence();
		u_m.write_byte(ROM_SKIP);
		u_m.write_byte(FN_WRITE);
		u_m.write_byte(8'h4b);
		u_m.write_byte(8'hc2);
		u_m.write_byte(8'h20);
		t_presence();
		u_m.write_byte(ROM_SKIP);
		u_m.write_byte(FN_READ);
		for (int i = 0; i < 40; i++) begin
			u_m.read_bit(r[i]);
		end
		check("th", 16'h004b, {8'h00, r[23:16]});
		check("tl", 16'h00c2, {8'h00, r[31:24]});
		check("cfg", {8'h00, cfg_exp}, {8'h00, r[39:32]});
		$display("test write done");
	endtask

	// Two search steps, the second answered with the wrong choice
	task automatic t_search;
		logic [3:0] v;
		logic       s;
		t_presence();
		u_m.write_byte(ROM_SEARCH);
		u_m.read_bit(v[0]);
		u_m.read_bit(v[1]);
		u_m.write_bit(ID_LOW[0]);
		u_m.read_bit(v[2]);
		u_m.read_bit(v[3]);
		check("search_bits", {12'h000, ~ID_LOW[1], ID_LOW[1], ~ID_LOW[0],
		                      ID_LOW[0]}, {12'h000, v});
		u_m.write_bit(~ID_LOW[1]);
		u_m.read_bit(s);
		check("withdrawn", 1, {15'h0, s});
		t_presence();
		$display("test search done");
	endtask

	// Parasite supply: status slots stay undriven and read as one
	task automatic t_parasite;
		logic v;
		parasite_mode <= 1'b1;
		t_presence();
		u_m.write_byte(ROM_SKIP);
		u_m.write_byte(FN_CONVERT);
		check("starts", 2, 16'(starts));
		u_m.read_bit(v);
		check("psv_busy", 1, {15'h0, v});
		@(posedge clock);
		conv_done <= 1'b1;
		temp_in   <= 16'h07f0;
		@(posedge clock) conv_done <= 1'b0;
		@(posedge clock);
		// Integer part 127 is above the high trigger written earlier
		check("alarm_hi", 1, {15'h0, alarm_flag});
		parasite_mode <= 1'b0;
		$display("test parasite done");
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		resetn        = 1'b0;
		parasite_mode = 1'b0;
		conv_done     = 1'b0;
		temp_in       = 16'h0000;
		fail_count    = 0;
		checks_done   = 0;
		starts        = 0;
		repeat (6) @(posedge clock);
		resetn <= 1'b1;
		repeat (4) @(posedge clock);
		t_convert();
		t_order();
		t_read_abort();
		t_write();
		t_search();
		t_parasite();
		end_sim();
	end
endmodule
